// ### accio_defs.vh
// constants for the accessory i/o and remote start block
// assumes apb with 32-bit data, one word per register
// Function
// - accessory input is active while its pin is low
// - an undriven input floats high through a pull-up and reads inactive
// - inputs are not latched; a read returns the level at that moment
// - status is 4095, minus 1 for input one, minus 2 for input two
// - output command argument n is accepted only for values zero to three
// - argument bit zero drives output one, bit one drives output two
// - an active output pulls its pin low, inactive releases it
// - ready line stays low unless gc, detector and data system are all ready
// - start contact closure begins a run only while the system is ready
`ifndef ACCIO_DEFS_VH
`define ACCIO_DEFS_VH
`define ACCIO_OFF_CMD 12'h000
`define ACCIO_OFF_RESP 12'h004
`define ACCIO_OFF_STAT 12'h008
`define ACCIO_OFF_READY 12'h00C
`define ACCIO_CMD_IN 16'h5000
`define ACCIO_CMD_OUT 16'h6F00
`define ACCIO_STATUS_IDLE 12'hFFF
`define ACCIO_BIT_RUN 0
`define ACCIO_BIT_BADARG 1
`define ACCIO_BIT_READY 2
`endif

// ### accio_sync.v
// two flip-flop synchroniser for a group of pin levels
// assumes the pins are asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module accio_sync #(
   parameter W = 4,
   parameter [W-1:0] INIT = {W{1'b1}}
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);
   reg [W-1:0] meta;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= INIT;
         q_o <= INIT;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // accio_sync
`default_nettype wire

// ### accio_top.v
// accessory input/output port with remote ready and start handling
// assumes an apb master on clk_i; pins arrive asynchronously
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "accio_defs.vh"
module accio_top (
   input wire clk_i,
   input wire rst_b_i,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire acc_in1_n_i,
   input wire acc_in2_n_i,
   output reg acc_out1_n_o,
   output reg acc_out1_oe_o,
   output reg acc_out2_n_o,
   output reg acc_out2_oe_o,
   input wire gc_ready_i,
   input wire detector_ready_i,
   input wire host_ready_i,
   input wire start_n_i,
   output reg system_ready_o,
   output reg run_start_o
);
   localparam ST_IDLE = 2'b01;
   localparam ST_RUN = 2'b10;

   // synchronised levels: bit 0 input one, bit 1 input two, bit 2 start contact
   wire [2:0] pins_s;
   reg [1:0] out_state;
   reg [11:0] resp;
   reg bad_arg;
   reg [1:0] state;
   reg [1:0] next_state;
   reg start_prev;
   reg [31:0] next_prdata;
   wire access;
   wire wr_en;
   wire rd_first;
   wire addr_ok;
   wire cmd_wr;
   wire stat_wr;
   wire [15:0] cmd_code;
   wire [15:0] cmd_arg;
   wire in_cmd;
   wire out_cmd;
   wire arg_ok;
   wire sys_ready;
   wire start_act;
   wire start_edge;
   wire run_begin;

   // pull-ups sit outside; reset value 1 means idle/inactive
   // levels only: a pulse shorter than one clock can be missed
   accio_sync #(.W(3), .INIT(3'h7)) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i({start_n_i, acc_in2_n_i, acc_in1_n_i}),
      .q_o(pins_s)
   );

   function [11:0] in_status;
      input n1;
      input n2;
      begin
         // low pin means active; undriven reads high = inactive
         in_status = `ACCIO_STATUS_IDLE - {10'h000, ~n2, ~n1};
      end
   endfunction

   function addr_is;
      input [11:0] a;
      input [11:0] off;
      begin
         addr_is = (a == off);
      end
   endfunction

   function is_mapped;
      input [11:0] a;
      begin
         is_mapped = addr_is(a, `ACCIO_OFF_CMD) | addr_is(a, `ACCIO_OFF_RESP) |
            addr_is(a, `ACCIO_OFF_STAT) | addr_is(a, `ACCIO_OFF_READY);
      end
   endfunction

   assign access = psel & penable;
   // a write lands on the edge that sees pready high, once per transfer
   assign wr_en = access & pwrite & pready;
   // read data is loaded one edge early so it stands while pready is high
   assign rd_first = access & ~pwrite & ~pready;
   assign addr_ok = is_mapped(paddr);
   assign cmd_wr = wr_en & addr_is(paddr, `ACCIO_OFF_CMD);
   assign stat_wr = wr_en & addr_is(paddr, `ACCIO_OFF_STAT);
   assign cmd_code = pwdata[31:16];
   assign cmd_arg = pwdata[15:0];
   assign in_cmd = cmd_wr & (cmd_code == `ACCIO_CMD_IN);
   assign out_cmd = cmd_wr & (cmd_code == `ACCIO_CMD_OUT);
   assign arg_ok = (cmd_arg <= 16'h0003);
   assign sys_ready = gc_ready_i & detector_ready_i & host_ready_i;
   assign start_act = ~pins_s[2];
   assign start_edge = start_act & ~start_prev;
   assign run_begin = (state == ST_IDLE) & (next_state == ST_RUN);

   // response word: sampled at the command, not latched from earlier pin activity
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         resp <= `ACCIO_STATUS_IDLE;
      end else if (in_cmd) begin
         resp <= in_status(pins_s[0], pins_s[1]);
      end
   end

   // output state only moves on an accepted output command
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_state <= 2'b00;
      end else if (out_cmd & arg_ok) begin
         out_state <= cmd_arg[1:0];
      end
   end

   // sticky until the next valid command, so software can look after the fact
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bad_arg <= 1'b0;
      end else if (out_cmd & ~arg_ok) begin
         bad_arg <= 1'b1;
      end else if (in_cmd | out_cmd) begin
         bad_arg <= 1'b0;
      end
   end

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            // closure while not ready is simply dropped
            if (start_edge & sys_ready) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stat_wr & pwdata[`ACCIO_BIT_RUN]) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // reset value matches an open contact, so no false edge follows reset
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         start_prev <= 1'b0;
      end else begin
         start_prev <= start_act;
      end
   end

   always @* begin
      next_prdata = 32'h0000_0000;
      if (addr_is(paddr, `ACCIO_OFF_RESP)) begin
         next_prdata = {20'h00000, resp};
      end else if (addr_is(paddr, `ACCIO_OFF_STAT)) begin
         next_prdata[`ACCIO_BIT_RUN] = state[1];
         next_prdata[`ACCIO_BIT_BADARG] = bad_arg;
         next_prdata[`ACCIO_BIT_READY] = sys_ready;
      end else if (addr_is(paddr, `ACCIO_OFF_CMD)) begin
         next_prdata = {30'h0, out_state};
      end else if (addr_is(paddr, `ACCIO_OFF_READY)) begin
         next_prdata = {31'h0, sys_ready};
      end
   end

   // one wait state: pready answers on the second access edge
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~addr_ok;
         if (rd_first) begin
            prdata <= next_prdata;
         end
      end
   end

   // open-drain style: the pin is only ever pulled low, never driven high
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_out1_n_o <= 1'b0;
         acc_out1_oe_o <= 1'b0;
         acc_out2_n_o <= 1'b0;
         acc_out2_oe_o <= 1'b0;
      end else begin
         acc_out1_n_o <= 1'b0;
         acc_out1_oe_o <= out_state[0];
         acc_out2_n_o <= 1'b0;
         acc_out2_oe_o <= out_state[1];
      end
   end

   // ready and start pulse are registered so the pins never glitch
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         system_ready_o <= 1'b0;
         run_start_o <= 1'b0;
      end else begin
         system_ready_o <= sys_ready;
         run_start_o <= run_begin;
      end
   end
endmodule // accio_top
`default_nettype wire

// ### accio_monitor.sv
// checker for the accessory port
// assumes binding to accio_top
`timescale 1ns/1ns
`default_nettype none
module accio_monitor (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic acc_in1_n_i,
   input wire logic acc_in2_n_i,
   input wire logic acc_out1_n_o,
   input wire logic acc_out1_oe_o,
   input wire logic acc_out2_n_o,
   input wire logic acc_out2_oe_o,
   input wire logic gc_ready_i,
   input wire logic detector_ready_i,
   input wire logic host_ready_i,
   input wire logic start_n_i,
   input wire logic system_ready_o,
   input wire logic run_start_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire [1:0] oe = {acc_out2_oe_o, acc_out1_oe_o};
   a_ready_and: assert property (system_ready_o == $past(gc_ready_i && detector_ready_i && host_ready_i))
      else $error("ready");
   a_start_ready: assert property (run_start_o |-> system_ready_o) else $error("start");
   a_start_pulse: assert property (run_start_o |=> !run_start_o) else $error("pulse");
   a_out_drain: assert property (!acc_out1_n_o && !acc_out2_n_o) else $error("drive");
   a_out_follow: assert property (psel && pready && pwrite && paddr == 12'h000 &&
      pwdata[31:2] == {16'h6F00, 14'h0} |-> ##2 oe == $past(pwdata[1:0], 2)) else $error("set");
   a_out_keep: assert property (!$stable(oe) |-> $past(psel && pready && pwrite && paddr == 12'h000, 2))
      else $error("keep");
   a_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("wait");
   a_stat_word: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:2] == 30'h3FF)
      else $error("word");
endmodule // accio_monitor
`default_nettype wire

// ### accessory_model.sv
// accessory side: pulled-up inputs, output loads, start contact
// assumes the bench chooses the driven lines
`timescale 1ns/1ns
`default_nettype none
module accessory_model (
   input wire logic [1:0] drv_i,
   input wire logic [1:0] oe_i,
   input wire logic close_i,
   input wire logic rude_i,
   input wire logic ready_i,
   output logic [1:0] in_n_o,
   output logic [1:0] pin_o,
   output logic start_n_o
);
   assign in_n_o = ~drv_i;
   assign pin_o = ~oe_i;
   // rude closes without waiting for ready
   assign start_n_o = !(close_i && (ready_i || rude_i));
endmodule // accessory_model
`default_nettype wire

// ### testbench.sv
// bench for the accessory port over apb
// assumes accio_top and the accessory model above
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0, err, cl = 0, rude = 0, sr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [1:0] drv = 0, oe, in_n, pin, out_n;
   logic [2:0] rdy = 0;
   logic pready, pslverr, st_n, rs;
   int n_fail = 0, checks = 0, cyc = 0, n_start = 0, i, j;
   always #10 clk_i = ~clk_i;
   accio_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acc_in1_n_i(in_n[0]), .acc_in2_n_i(in_n[1]), .acc_out1_n_o(out_n[0]), .acc_out1_oe_o(oe[0]),
      .acc_out2_n_o(out_n[1]), .acc_out2_oe_o(oe[1]), .gc_ready_i(rdy[0]), .detector_ready_i(rdy[1]),
      .host_ready_i(rdy[2]), .start_n_i(st_n), .system_ready_o(sr), .run_start_o(rs));
   accessory_model far (.drv_i(drv), .oe_i(oe), .close_i(cl), .rude_i(rude), .ready_i(sr),
      .in_n_o(in_n), .pin_o(pin), .start_n_o(st_n));
   task tally_and_finish;
      if (n_fail == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   endtask
   task apb_access(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i) penable <= 1;
      do @(posedge clk_i); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (rs === 1'b1)
         n_start++;
      if (cyc > 3000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1;
      for (i = 0; i < 4; i++) begin
         drv <= i[1:0];
         repeat (4) @(posedge clk_i);
         repeat (2) begin
            apb_access(1, 12'h000, 32'h5000_0000);
            apb_access(0, 12'h004, 32'h0);
            chk(r, 32'h0000_0FFF - i);
         end
      end
      for (i = 0; i < 5; i++) begin
         j = (i < 4) ? i : 3;
         apb_access(1, 12'h000, 32'h6F00_0000 + i);
         apb_access(0, 12'h000, 32'h0);
         chk({28'h0, r[1:0], pin}, {28'h0, j[1:0], ~j[1:0]});
      end
      chk({30'h0, out_n}, 32'h0);
      apb_access(0, 12'h008, 32'h0);
      chk({31'h0, r[1]}, 32'h1);
      apb_access(1, 12'h000, 32'h6F00_0003);
      apb_access(0, 12'h008, 32'h0);
      chk({31'h0, r[1]}, 32'h0);
      apb_access(1, 12'h000, 32'h5000_0000);
      chk({30'h0, pin}, 32'h0);
      apb_access(0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      rude <= 1;
      cl <= 1;
      rdy <= 3'h3;
      repeat (8) @(posedge clk_i);
      rude <= 0;
      cl <= 0;
      chk({31'h0, sr}, 32'h0);
      apb_access(0, 12'h008, 32'h0);
      chk({29'h0, r[2:0] & 3'h5}, 32'h0);
      chk(n_start, 32'h0);
      rdy <= 3'h7;
      repeat (3) @(posedge clk_i);
      chk({31'h0, sr}, 32'h1);
      apb_access(0, 12'h00C, 32'h0);
      chk(r, 32'h1);
      cl <= 1;
      repeat (8) @(posedge clk_i);
      cl <= 0;
      apb_access(0, 12'h008, 32'h0);
      chk({29'h0, r[2:0] & 3'h5}, 32'h5);
      chk(n_start, 32'h1);
      repeat (3) @(posedge clk_i);
      cl <= 1;
      repeat (8) @(posedge clk_i);
      cl <= 0;
      chk(n_start, 32'h1);
      apb_access(1, 12'h008, 32'h1);
      apb_access(0, 12'h008, 32'h0);
      chk({29'h0, r[2:0] & 3'h5}, 32'h4);
      repeat (3) @(posedge clk_i);
      cl <= 1;
      repeat (8) @(posedge clk_i);
      cl <= 0;
      chk(n_start, 32'h2);
      tally_and_finish;
   end
endmodule // testbench
bind accio_top accio_monitor mon (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .acc_in1_n_i(acc_in1_n_i), .acc_in2_n_i(acc_in2_n_i), .acc_out1_n_o(acc_out1_n_o),
   .acc_out1_oe_o(acc_out1_oe_o), .acc_out2_n_o(acc_out2_n_o), .acc_out2_oe_o(acc_out2_oe_o),
   .gc_ready_i(gc_ready_i), .detector_ready_i(detector_ready_i), .host_ready_i(host_ready_i),
   .start_n_i(start_n_i), .system_ready_o(system_ready_o), .run_start_o(run_start_o));
`default_nettype wire
